// *** core/rcs_seq.sv ***
// rcs_seq: reset pin sequencing, boot strap hold, pll lock and clock-out control
//
// Overview of operation
// - system clock is oscillator over four after power-up
// - clock-out divider resets to zero, divide four
// - clock-out pin stays off until software enables
// - boot pins sampled, held 1000 system cycles
// - device drives reset pin low 600 us
// - bus activity starts 32 cycles after pin high
// - pll multiplier write starts lock phase immediately
// - during lock system clock is oscillator over two
// - after lock system clock follows new multiplier
// - internal oscillator ready only after 3 us
// - power-on reset generated internally, pin optional
`timescale 1ns/100ps
module rcs_seq
	import rcs_pkg::*;
#(
	parameter int DRIVE_CYCLES = PIN_DRIVE_CYC                // self-driven pin pulse length
)(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [7:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack,
	input  wire logic        device_reset_pin_n_in,
	output logic             device_reset_pin_n_out,
	output logic             device_reset_pin_n_oe_n,
	input  wire logic [1:0]  boot_mode_pins,
	input  wire logic        watchdog_reset_req,
	output logic             cpu_run,
	output logic             boot_done,
	output logic [1:0]       boot_mode,
	output logic             system_clock_en,
	output rcs_ratio_t       system_clock_ratio,
	output logic             clock_out_pin
);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	rcs_state_t       state_r;                                // sequencer state
	logic [CNT_W-1:0] cnt_r;                                  // per-state counter
	logic             rpin_q1, rpin_s;                        // reset pin synchroniser
	logic [1:0]       boot_q1, boot_s;                        // boot pin synchroniser
	logic [5:0]       low_cnt_r;                              // consecutive pin low cycles
	logic             warm_hit;                               // pin low long enough
	logic             cfg_live;                               // registers writable
	logic             wr_acc, rd_acc;                         // bus access this cycle
	logic [1:0]       clkout_div_r;                           // clock_out_divider
	logic             clkout_en_r;                            // pin function select
	logic [1:0]       sysdiv_r;                               // system_clock_divide_select
	logic [4:0]       pll_mul_r;                              // pll_multiplier_register
	logic [15:0]      lock_cnt_r;                             // pll_lock_wait_count
	logic [15:0]      lock_left_r;                            // lock phase remaining
	logic             lock_busy_r;                            // lock phase running
	logic             boot_err_r, wd_flag_r, ext_flag_r;      // status flags
	logic             clk_int_r, phase_r;                     // clock-out divider
	logic [3:0]       divd;                                   // system divide factor
	rcs_ratio_t       ratio_nxt;                              // next system clock ratio
	logic             sys_en;                                 // system clock enable
	logic [14:0]      drive_len_h;                            // helper: pin drive length
	logic [5:0]       hi_cnt_h;                               // helper: pin high cycles
	logic [9:0]       boot_en_h;                              // helper: enables while booting

	assign warm_hit = (low_cnt_r >= 6'(WARM_MIN_CYC));
	assign cfg_live = (state_r == ST_BOOT) || (state_r == ST_RUN);
	// a write commits at the edge where the master samples ack high
	assign wr_acc   = wb_cyc && wb_stb && wb_we && wb_ack;
	assign rd_acc   = wb_cyc && wb_stb && !wb_we && !wb_ack;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rpin_q1 <= 1'b1;
			rpin_s  <= 1'b1;
			boot_q1 <= 2'h0;
			boot_s  <= 2'h0;
		end else begin
			rpin_q1 <= device_reset_pin_n_in;
			rpin_s  <= rpin_q1;
			boot_q1 <= boot_mode_pins;
			boot_s  <= boot_q1;
		end
	end

	// low-time filter: shorter pulses are ignored while the device does not drive
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			low_cnt_r <= 6'h00;
		end else if (rpin_s || !device_reset_pin_n_oe_n) begin
			low_cnt_r <= 6'h00;
		end else if (!warm_hit) begin
			low_cnt_r <= low_cnt_r + 6'h01;
		end
	end

	// ------------------------------------------------------------------
	// reset sequence
	// ------------------------------------------------------------------
	// rst is the internal power-on reset; the pin is never needed to start
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_OSC;
			cnt_r   <= '0;
		end else begin
			case (state_r)
				ST_OSC: begin
					if (cnt_r == CNT_W'(OSC_START_CYC - 1)) begin
						state_r <= ST_DRIVE;
						cnt_r   <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ST_DRIVE: begin
					if (cnt_r == CNT_W'(DRIVE_CYCLES - 1)) begin
						state_r <= ST_RELEASE;
						cnt_r   <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ST_RELEASE, ST_EXT: begin
					if (rpin_s) begin
						state_r <= ST_DELAY;
						cnt_r   <= '0;
					end
				end
				ST_DELAY: begin
					if (warm_hit) begin
						state_r <= ST_EXT;
					end else if (!rpin_s) begin
						cnt_r <= '0;                             // pin bounced low
					end else if (cnt_r == CNT_W'(BUS_DELAY_CYC - 1)) begin
						state_r <= ST_BOOT;
						cnt_r   <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ST_BOOT, ST_RUN: begin
					if (warm_hit) begin
						state_r <= ST_EXT;
					end else if (watchdog_reset_req) begin
						state_r <= ST_WD;
						cnt_r   <= '0;
					end else if (state_r == ST_BOOT && sys_en) begin
						if (cnt_r == CNT_W'(BOOT_HOLD_SYS - 1)) begin
							state_r <= ST_RUN;
							cnt_r   <= '0;
						end else begin
							cnt_r <= cnt_r + 1'b1;
						end
					end
				end
				ST_WD: begin
					if (cnt_r == CNT_W'(WD_PULSE_CYC - 1)) begin
						state_r <= ST_RELEASE;
						cnt_r   <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: begin
					state_r <= ST_OSC;
					cnt_r   <= '0;
				end
			endcase
		end
	end

	// pin drive, run outputs, boot capture and reset-cause flags
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			device_reset_pin_n_out  <= 1'b0;
			device_reset_pin_n_oe_n <= 1'b1;
			cpu_run    <= 1'b0;
			boot_done  <= 1'b0;
			boot_mode  <= 2'h0;
			boot_err_r <= 1'b0;
			wd_flag_r  <= 1'b0;
			ext_flag_r <= 1'b0;
		end else begin
			device_reset_pin_n_out  <= 1'b0;                   // open drain, low only
			device_reset_pin_n_oe_n <= (state_r != ST_DRIVE);
			cpu_run   <= cfg_live;
			boot_done <= (state_r == ST_RUN);
			if (state_r == ST_DELAY) begin
				boot_mode  <= boot_s;
				boot_err_r <= 1'b0;
			end else if (state_r == ST_BOOT && boot_s != boot_mode) begin
				boot_err_r <= 1'b1;
			end
			if (state_r == ST_WD) begin
				wd_flag_r  <= 1'b1;
				ext_flag_r <= 1'b0;
			end else if (state_r == ST_EXT) begin
				wd_flag_r  <= 1'b0;
				ext_flag_r <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// configuration registers, back to reset values in every reset phase
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clkout_div_r <= CLKOUT_DIV_RST;
			clkout_en_r  <= 1'b0;
			sysdiv_r     <= SYSDIV_RST;
			pll_mul_r    <= PLL_MUL_RST;
			lock_cnt_r   <= LOCK_CNT_RST;
		end else if (!cfg_live) begin
			clkout_div_r <= CLKOUT_DIV_RST;
			clkout_en_r  <= 1'b0;
			sysdiv_r     <= SYSDIV_RST;
			pll_mul_r    <= PLL_MUL_RST;
			lock_cnt_r   <= LOCK_CNT_RST;
		end else if (wr_acc && wb_sel[0]) begin
			case (wb_adr)
				REG_CLKOUT_CFG: begin
					clkout_div_r <= wb_dat_i[CLKOUT_DIV_LSB +: 2];
					clkout_en_r  <= wb_dat_i[CLKOUT_EN_BIT];
				end
				REG_SYSDIV:   sysdiv_r  <= wb_dat_i[1:0];
				REG_PLL_MUL:  pll_mul_r <= wb_dat_i[4:0];
				// a value below the software minimum is taken as written
				REG_LOCK_CNT: begin
					lock_cnt_r[7:0] <= wb_dat_i[7:0];
					if (wb_sel[1]) begin
						lock_cnt_r[15:8] <= wb_dat_i[15:8];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// lock phase: restarts on every multiplier write
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lock_busy_r <= 1'b0;
			lock_left_r <= 16'h0000;
		end else if (!cfg_live) begin
			lock_busy_r <= 1'b0;
			lock_left_r <= 16'h0000;
		end else if (wr_acc && wb_sel[0] && wb_adr == REG_PLL_MUL) begin
			lock_busy_r <= 1'b1;
			lock_left_r <= lock_cnt_r;
		end else if (lock_busy_r) begin
			if (lock_left_r <= 16'h0001) begin
				lock_busy_r <= 1'b0;
			end
			lock_left_r <= (lock_left_r == 16'h0000) ? 16'h0000 : lock_left_r - 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// system clock rate
	// ------------------------------------------------------------------
	always_comb begin
		case (sysdiv_r)
			2'h2:    divd = 4'h2;
			2'h3:    divd = 4'h1;
			default: divd = 4'h4;
		endcase
		if (!cfg_live) begin
			ratio_nxt = '{num: 5'h01, den: 4'h4};
		end else if (lock_busy_r) begin
			ratio_nxt = '{num: 5'h01, den: 4'h2};
		end else if (pll_mul_r == 5'h00) begin
			ratio_nxt = '{num: 5'h01, den: divd};
		end else begin
			ratio_nxt = '{num: pll_mul_r, den: {divd[2:0], 1'b0}};
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			system_clock_ratio <= '{num: 5'h01, den: 4'h4};
		end else begin
			system_clock_ratio <= ratio_nxt;
		end
	end

	rcs_rate_gen u_rate (
		.ref_clk (ref_clk),
		.rst     (rst),
		.ratio   (system_clock_ratio),
		.en      (sys_en)
	);
	assign system_clock_en = sys_en;

	// ------------------------------------------------------------------
	// clock-out pin
	// ------------------------------------------------------------------
	// divider 0 toggles every second enable, any other value every enable
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_r       <= 1'b0;
			clk_int_r     <= 1'b0;
			clock_out_pin <= 1'b0;
		end else begin
			if (sys_en) begin
				phase_r <= ~phase_r;
				if (clkout_div_r != 2'h0 || phase_r) begin
					clk_int_r <= ~clk_int_r;
				end
			end
			// gated by the boot and run phases so the pin drops on the second reset cycle
			clock_out_pin <= cfg_live & clkout_en_r & clk_int_r;
		end
	end

	// ------------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wb_ack   <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack   <= wb_cyc && wb_stb && !wb_ack;
			wb_dat_o <= 32'h0000_0000;
			if (rd_acc) begin
				case (wb_adr)
					REG_CLKOUT_CFG: wb_dat_o[2:0]  <= {clkout_en_r, clkout_div_r};
					REG_SYSDIV:     wb_dat_o[1:0]  <= sysdiv_r;
					REG_PLL_MUL:    wb_dat_o[4:0]  <= pll_mul_r;
					REG_LOCK_CNT:   wb_dat_o[15:0] <= lock_cnt_r;
					REG_STATUS:     wb_dat_o[6:0]  <= {boot_done, ext_flag_r, wd_flag_r,
						boot_mode, boot_err_r, lock_busy_r};
					default:        wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// helpers and assertions
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			drive_len_h <= 15'h0000;
			hi_cnt_h    <= 6'h00;
			boot_en_h   <= 10'h000;
		end else begin
			drive_len_h <= device_reset_pin_n_oe_n ? 15'h0000 : drive_len_h + 15'h0001;
			hi_cnt_h    <= !rpin_s ? 6'h00 : (&hi_cnt_h ? hi_cnt_h : hi_cnt_h + 6'h01);
			boot_en_h   <= !cfg_live ? 10'h000 :
				((state_r == ST_BOOT && sys_en) ? boot_en_h + 10'h001 : boot_en_h);
		end
	end

	a_drive_len: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(device_reset_pin_n_oe_n) |-> drive_len_h == 15'(DRIVE_CYCLES))
		else $error("reset pin drive length wrong");
	a_bus_delay: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(cpu_run) |-> hi_cnt_h >= 6'(BUS_DELAY_CYC))
		else $error("bus activity before quiet time");
	a_boot_hold: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(boot_done) |-> boot_en_h == 10'(BOOT_HOLD_SYS))
		else $error("boot hold not 1000 system cycles");
	a_warm_min: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(state_r == ST_EXT) |-> $past(low_cnt_r) >= 6'(WARM_MIN_CYC))
		else $error("warm reset taken on short pulse");
	a_lock_start: assert property (@(posedge ref_clk) disable iff (rst)
		(wr_acc && wb_sel[0] && wb_adr == REG_PLL_MUL && cfg_live) |=> lock_busy_r)
		else $error("multiplier write did not start lock");
	a_lock_half: assert property (@(posedge ref_clk) disable iff (rst)
		(lock_busy_r && cfg_live) ##1 cfg_live |-> system_clock_ratio.den == 4'h2
		&& system_clock_ratio.num == 5'h01)
		else $error("lock phase not at half rate");
	a_new_ratio: assert property (@(posedge ref_clk) disable iff (rst)
		($fell(lock_busy_r) && cfg_live && pll_mul_r != 5'h00) |=>
		system_clock_ratio.num == $past(pll_mul_r, 2))
		else $error("multiplier not applied after lock");
	a_quarter_reset: assert property (@(posedge ref_clk) disable iff (rst)
		!cfg_live |=> system_clock_ratio.num == 5'h01 && system_clock_ratio.den == 4'h4)
		else $error("reset rate not a quarter");
	a_clkout_off: assert property (@(posedge ref_clk) disable iff (rst)
		(!cfg_live) [*2] |-> !clock_out_pin && clkout_div_r == CLKOUT_DIV_RST)
		else $error("clock-out active during reset");
	a_osc_ready: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(state_r == ST_DRIVE) |-> $past(cnt_r) == CNT_W'(OSC_START_CYC - 1))
		else $error("oscillator taken as ready too early");

endmodule

// *** core/rcs_pkg.sv ***
// rcs_pkg: constants, register map and types of the reset and clock sequencer
package rcs_pkg;

	// ------------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_PS  = 25000;                    // ref_clk period, 40 MHz
	localparam int OSC_START_NS   = 3000;                     // internal oscillator start-up
	localparam int OSC_START_CYC  = (OSC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PIN_DRIVE_US   = 600;                      // self-driven reset pulse
	localparam int PIN_DRIVE_CYC  = PIN_DRIVE_US * 1000000 / CLK_PERIOD_PS;
	localparam int BUS_DELAY_CYC  = 32;                       // pin high to bus activity
	localparam int WARM_MIN_CYC   = 32;                       // shortest accepted warm reset
	localparam int BOOT_HOLD_SYS  = 1000;                     // boot pin hold, system cycles
	localparam int WD_PULSE_CYC   = 512;                      // internal watchdog reset pulse
	localparam int CNT_W          = 15;                       // sequence counter width

	// ------------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] REG_CLKOUT_CFG = 8'h00;            // clock_out_config_register
	localparam logic [7:0] REG_SYSDIV     = 8'h04;            // system_clock_divide_select
	localparam logic [7:0] REG_PLL_MUL    = 8'h08;            // pll_multiplier_register
	localparam logic [7:0] REG_LOCK_CNT   = 8'h0C;            // pll_lock_wait_count
	localparam logic [7:0] REG_STATUS     = 8'h10;            // sequencer status, read only

	// field positions and reset values
	localparam int CLKOUT_DIV_LSB = 0;                        // clock_out_divider [1:0]
	localparam int CLKOUT_EN_BIT  = 2;                        // clock-out pin function enable
	localparam logic [1:0]  CLKOUT_DIV_RST = 2'h0;            // divide by four
	localparam logic [1:0]  SYSDIV_RST     = 2'h0;            // divide by four
	localparam logic [4:0]  PLL_MUL_RST    = 5'h00;           // pll bypassed
	localparam logic [15:0] LOCK_CNT_RST   = 16'hFFFF;
	localparam int ST_LOCK_BIT = 0;
	localparam int ST_BERR_BIT = 1;
	localparam int ST_BMODE_LSB = 2;                          // boot mode [3:2]
	localparam int ST_WD_BIT   = 4;
	localparam int ST_EXT_BIT  = 5;
	localparam int ST_DONE_BIT = 6;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OSC     = 3'b000,                                  // oscillator start-up
		ST_DRIVE   = 3'b001,                                  // device drives reset pin
		ST_RELEASE = 3'b010,                                  // wait for pin to read high
		ST_DELAY   = 3'b011,                                  // quiet time before bus activity
		ST_BOOT    = 3'b100,                                  // boot pins sampled and held
		ST_RUN     = 3'b101,                                  // normal operation
		ST_WD      = 3'b110,                                  // watchdog reset pulse
		ST_EXT     = 3'b111                                   // external warm reset held
	} rcs_state_t;

	// system clock rate as oscillator_clock * num / den
	typedef struct packed {
		logic [4:0] num;
		logic [3:0] den;
	} rcs_ratio_t;

endpackage

// *** core/rcs_rate_gen.sv ***
// rcs_rate_gen: fractional enable generator for the system clock rate
`timescale 1ns/100ps
module rcs_rate_gen
	import rcs_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire rcs_ratio_t ratio,
	output logic            en
);

	// ------------------------------------------------------------------
	// phase accumulator
	// ------------------------------------------------------------------
	logic [5:0] acc_r;                                        // phase, kept below den
	logic [5:0] sum;                                          // phase plus step
	logic [5:0] rem;                                          // phase after one wrap

	always_comb begin
		sum = acc_r + {1'b0, ratio.num};
		rem = sum - {2'h0, ratio.den};
	end

	// rates above the oscillator saturate to an enable every cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc_r <= 6'h00;
			en    <= 1'b0;
		end else if (sum >= {2'h0, ratio.den}) begin
			acc_r <= (rem >= {2'h0, ratio.den}) ? 6'h00 : rem;
			en    <= 1'b1;
		end else begin
			acc_r <= sum;
			en    <= 1'b0;
		end
	end

endmodule

// *** sim/rcs_strap_model.sv ***
// rcs_strap_model: external reset source and boot strap pins beside the sequencer
`timescale 1ns/100ps
module rcs_strap_model
	import rcs_pkg::*;
(
	input  wire logic  ref_clk,
	input  wire logic  dev_oe_n,
	output logic       pin_level_n,
	output logic [1:0] strap
);
	// --------------------------------
	// reset line and straps
	// --------------------------------
	logic       ext_low_r = 1'b0;                   // external source pulls the line
	logic [1:0] strap_r   = 2'h2;                   // strap never moves during a hold
	// open drain line with pull-up: low if either party pulls
	assign pin_level_n = ~(ext_low_r | ~dev_oe_n);
	assign strap       = strap_r;
	// warm reset request: line held low for n whole cycles
	task automatic pulse(input int n);
		ext_low_r <= 1'b1;
		repeat (n) @(posedge ref_clk);
		ext_low_r <= 1'b0;
	endtask
endmodule

// *** sim/tb_reset_and_clock_sequencing.sv ***
// tb_reset_and_clock_sequencing: self-checking bench of the sequencer
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t line %0d", $time, `__LINE__); end end
module tb_reset_and_clock_sequencing
	import rcs_pkg::*;
;
	// --------------------------------
	// signals
	// --------------------------------
	logic ref_clk = 1'b0, rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wdog = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic        wb_ack, pin_n, pin_out, oe_n, cpu_run, boot_done, sys_en, clk_out;
	logic [1:0]  straps, boot_mode;
	rcs_ratio_t  ratio;
	int          error_cnt = 0, comparisons = 0, n;
	always #12.5 ref_clk = ~ref_clk;                // 40 MHz
	rcs_seq #(.DRIVE_CYCLES(40)) i_rcs_seq (.ref_clk(ref_clk), .rst(rst), .wb_cyc(wb_cyc),
		.wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .device_reset_pin_n_in(pin_n),
		.device_reset_pin_n_out(pin_out), .device_reset_pin_n_oe_n(oe_n), .boot_mode_pins(straps),
		.watchdog_reset_req(wdog), .cpu_run(cpu_run), .boot_done(boot_done),
		.boot_mode(boot_mode), .system_clock_en(sys_en), .system_clock_ratio(ratio),
		.clock_out_pin(clk_out));
	rcs_strap_model i_rcs_strap_model (.ref_clk(ref_clk), .dev_oe_n(oe_n),
		.pin_level_n(pin_n), .strap(straps));
	// --------------------------------
	// helpers
	// --------------------------------
	function automatic logic pick(input int s);
		case (s)
			0: return oe_n;
			1: return cpu_run;
			2: return boot_done;
			3: return clk_out;
			default: return sys_en;
		endcase
	endfunction
	// wait until a watched output takes a level, counting edges
	task automatic wait_sig(input int s, input logic v, input int lim);
		n = 0;
		while (pick(s) !== v && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK(n < lim, 1'b1)
	endtask
	// count rising transitions of a watched output over c cycles
	task automatic edges(input int s, input int c);
		logic p;
		n = 0;
		p = pick(s);
		repeat (c) begin
			@(posedge ref_clk);
			if (pick(s) === 1'b1 && p === 1'b0) n++;
			p = pick(s);
		end
	endtask
	// one classic bus cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_sel <= 4'hF;
		wb_adr <= a;
		wb_dat_i <= d;
		// the wait has no cycle limit and only the bench watchdog ends a hung one; ack is checked to come on the second edge
		do begin
			@(posedge ref_clk);
			k++;
		end while (wb_ack !== 1'b1);
		`CHK(k, 2)
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_sel <= 4'h0;
		@(posedge ref_clk);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_power();
		`CHK(ratio, {5'h01, 4'h4})
		wait_sig(0, 1'b0, 500);
		`CHK(n >= OSC_START_CYC, 1'b1)
		`CHK(pin_out, 1'b0)
		wait_sig(0, 1'b1, 100);
		`CHK(n, 40)
		wait_sig(1, 1'b1, 200);
		`CHK(n >= 32 && n <= 40, 1'b1)
		`CHK(boot_mode, 2'h2)
		wait_sig(2, 1'b1, 5000);
		`CHK(n >= 3990 && n <= 4010, 1'b1)
		$display("power-up done");
	endtask
	task automatic t_clkout();
		wb(1'b0, REG_CLKOUT_CFG, 32'h0);
		`CHK(q, 32'h0)
		wb(1'b0, 8'h14, 32'h0);
		`CHK(q, 32'h0)
		edges(3, 64);
		`CHK(n, 0)
		edges(4, 64);
		`CHK(n, 16)
		wb(1'b1, REG_CLKOUT_CFG, 32'h4);
		repeat (16) @(posedge ref_clk);
		edges(3, 64);
		`CHK(n, 4)
		wb(1'b1, REG_CLKOUT_CFG, 32'h5);
		repeat (16) @(posedge ref_clk);
		edges(3, 64);
		`CHK(n, 8)
		$display("clock-out done");
	endtask
	task automatic t_pll();
		wb(1'b1, REG_SYSDIV, 32'h2);
		repeat (4) @(posedge ref_clk);
		edges(4, 64);
		`CHK(n, 32)
		wb(1'b1, REG_SYSDIV, 32'h3);
		wb(1'b1, REG_LOCK_CNT, 32'd10000);
		wb(1'b1, REG_PLL_MUL, 32'h8);
		@(posedge ref_clk);
		`CHK(ratio, {5'h01, 4'h2})
		edges(4, 64);
		`CHK(n, 32)
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK(q[ST_LOCK_BIT], 1'b1)
		repeat (10000) @(posedge ref_clk);
		`CHK(ratio, {5'h08, 4'h2})
		$display("pll done");
	endtask
	task automatic t_warm();
		i_rcs_strap_model.pulse(20);
		repeat (60) @(posedge ref_clk);
		`CHK(cpu_run, 1'b1)
		i_rcs_strap_model.pulse(40);
		`CHK(cpu_run, 1'b0)
		wait_sig(1, 1'b1, 200);
		`CHK(n >= 32 && n <= 40, 1'b1)
		`CHK(ratio, {5'h01, 4'h4})
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK(q[ST_EXT_BIT], 1'b1)
		`CHK(q[ST_BERR_BIT], 1'b0)
		$display("warm reset done");
	endtask
	task automatic t_wdog();
		wdog <= 1'b1;
		@(posedge ref_clk);
		wdog <= 1'b0;
		wait_sig(1, 1'b0, 10);
		wait_sig(1, 1'b1, 700);
		`CHK(n >= 512 && n <= 560, 1'b1)
		`CHK(oe_n, 1'b1)
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK(q[ST_WD_BIT], 1'b1)
		$display("watchdog done");
	endtask
	// --------------------------------
	// main sequence and watchdog
	// --------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_power();
		t_clkout();
		t_pll();
		t_warm();
		t_wdog();
		end_of_test();
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		error_cnt++;
		end_of_test();
	end
endmodule
